// File: rfc_pkg.sv
`default_nettype none
package rfc_pkg;
    // Control modes
    typedef enum logic [1:0]
    {
        RFC_MODE_POSITION,
        RFC_MODE_POSITIONING,
        RFC_MODE_SPEED,
        RFC_MODE_TORQUE
    } rfc_mode_t;

    localparam logic [1:0] RFC_TRACE_ENABLED  = 2'h2;
    localparam logic [1:0] RFC_ADAPT_PID      = 2'h2;
    localparam logic       RFC_INP_CMD_DONE   = 1'h1;
    localparam logic       RFC_UNIT_KPULSE    = 1'h1;
    localparam int         RFC_KPULSE_FACTOR  = 1000;
    localparam int         RFC_CLK_MHZ        = 100;
    // Delay and filter time unit: 0.1 ms
    localparam int         RFC_TIME_UNIT_US   = 100;
    localparam int         RFC_TICK_CYCLES    =
        RFC_TIME_UNIT_US * RFC_CLK_MHZ;
    localparam logic [15:0] RFC_DELAY_RESET   = 16'h0000;
    localparam int         RFC_FILT_SHIFT     = 4;
endpackage
`default_nettype wire

// File: rfc_highpass.sv
`default_nettype none
module rfc_highpass
    import rfc_pkg::*;
#(
    parameter int W = 24
)
(
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic                tick_in,
    input  wire logic                load_in,
    input  wire logic signed [W-1:0] step_in,
    input  wire logic        [15:0]  tc_in,
    output var  logic signed [W-1:0] value_out
);
    // ----------------------------------------
    // Step decay toward zero
    // ----------------------------------------
    logic signed [W-1:0] acc_reg;
    logic signed [W-1:0] acc_next;
    logic        [15:0]  cnt_reg;
    logic        [15:0]  cnt_next;
    logic signed [W-1:0] bleed;

    // Shift the magnitude so both signs decay alike toward zero
    assign bleed = acc_reg[W-1] ? -((-acc_reg) >>> RFC_FILT_SHIFT)
                                : (acc_reg >>> RFC_FILT_SHIFT);

    always_comb
    begin
        acc_next = acc_reg;
        cnt_next = cnt_reg;
        if (load_in)
        begin
            acc_next = step_in;
            cnt_next = 16'h0000;
        end
        else if (tc_in == 16'h0000)
        begin
            cnt_next = 16'h0000;
        end
        else if (tick_in)
        begin
            // Bleed one shift-step once per time constant share
            if (cnt_reg >= (tc_in >> RFC_FILT_SHIFT))
            begin
                cnt_next = 16'h0000;
                acc_next = acc_reg - bleed
                           - W'(acc_reg > 0)
                           + W'(acc_reg < 0);
            end
            else
            begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            acc_reg <= '0;
            cnt_reg <= 16'h0000;
        end
        else
        begin
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
        end
    end

    assign value_out = acc_reg;
endmodule
`default_nettype wire

// File: rfc_top.sv
// What this block does
// - Droop compensation acts only in position or positioning mode.
// - PID selection keeps droop compensation off whatever else is set.
// - Droop compensation is enabled when trace select equals 2.
// - With condition 1, in-position needs range plus command done.
// - Model error cancels residual following error left by feedforward.
// - Lost-motion compensation acts only in position or positioning mode.
// - Lost-motion enable bit: 0 off, 1 on.
// - Every travel reversal after the first move since reset or enable triggers lost-motion compensation.
// - Separate amounts for forward-to-reverse and reverse-to-forward.
// - Each compensation starts after the programmed delay, default 0.
// - Droop fluctuation within dead band counts as zero speed.
// - Nonzero filter constant makes the amount decay through high-pass.
`default_nettype none
module rfc_top
    import rfc_pkg::*;
#(
    parameter int W = 24
)
(
    // Clock and reset
    input  wire logic                CLK_SYS_IN,
    input  wire logic                RST_IN,
    // Configuration
    input  wire rfc_mode_t           CTRL_MODE_IN,
    input  wire logic        [1:0]   TRACE_COMP_SELECT_IN,
    input  wire logic        [1:0]   ADAPTIVE_MODEL_SELECT_IN,
    input  wire logic                INPOS_CONDITION_SELECT_IN,
    input  wire logic                BACKLASH_COMP_ENABLE_IN,
    input  wire logic                DEADBAND_UNIT_SELECT_IN,
    input  wire logic signed [W-1:0] COMP_AMOUNT_DIR_ONE_IN,
    input  wire logic signed [W-1:0] COMP_AMOUNT_DIR_TWO_IN,
    input  wire logic        [15:0]  COMP_DELAY_TIME_IN,
    input  wire logic        [15:0]  COMP_DEADBAND_IN,
    input  wire logic        [15:0]  COMP_HIGHPASS_TC_IN,
    input  wire logic        [W-1:0] INPOS_RANGE_IN,
    // Loop signals
    input  wire logic signed [W-1:0] DROOP_IN,
    input  wire logic signed [W-1:0] MODEL_DROOP_IN,
    input  wire logic signed [W-1:0] TORQUE_CMD_IN,
    input  wire logic                CMD_DONE_IN,
    // Results
    output var  logic signed [W-1:0] DROOP_COMP_OUT,
    output var  logic signed [W-1:0] TORQUE_CMD_OUT,
    output var  logic                IN_POSITION_OUTPUT_OUT,
    output var  logic                REVERSAL_OUT
);
    function automatic logic [W-1:0] abs_w(input logic signed [W-1:0] v);
        abs_w = v[W-1] ? W'(-v) : W'(v);
    endfunction

    // ----------------------------------------
    // Mode gating
    // ----------------------------------------
    logic pos_mode;
    logic trace_on;
    logic lost_on;
    assign pos_mode = (CTRL_MODE_IN == RFC_MODE_POSITION) ||
                      (CTRL_MODE_IN == RFC_MODE_POSITIONING);
    assign trace_on = pos_mode &&
                      (ADAPTIVE_MODEL_SELECT_IN != RFC_ADAPT_PID) &&
                      (TRACE_COMP_SELECT_IN == RFC_TRACE_ENABLED);
    assign lost_on  = pos_mode && BACKLASH_COMP_ENABLE_IN;

    // ----------------------------------------
    // Droop compensation and in-position
    // ----------------------------------------
    logic signed [W-1:0] droop_comp_reg;
    logic signed [W-1:0] droop_comp_next;
    logic                inpos_reg;
    logic                inpos_next;
    logic                in_range;

    assign in_range = abs_w(DROOP_IN) <= INPOS_RANGE_IN;

    always_comb
    begin
        // Model droop is the ideal error the feedforward leaves behind
        droop_comp_next = trace_on ? W'(-MODEL_DROOP_IN) : '0;
        if (INPOS_CONDITION_SELECT_IN == RFC_INP_CMD_DONE)
            inpos_next = in_range && CMD_DONE_IN;
        else
            inpos_next = in_range;
    end

    // ----------------------------------------
    // Reversal detection with dead band
    // ----------------------------------------
    logic signed [W-1:0] prev_droop_reg;
    logic        [1:0]   dir_reg;
    logic        [1:0]   dir_next;
    logic        [W+9:0] band;
    logic signed [W:0]   delta;
    logic                reversal;

    // dir: 00 none yet, 01 forward, 10 reverse
    assign band  = (DEADBAND_UNIT_SELECT_IN == RFC_UNIT_KPULSE)
                   ? (W+10)'(COMP_DEADBAND_IN * RFC_KPULSE_FACTOR)
                   : (W+10)'(COMP_DEADBAND_IN);
    assign delta = (W+1)'(DROOP_IN) - (W+1)'(prev_droop_reg);

    // First move after reset or enable only sets the direction
    always_comb
    begin
        dir_next = dir_reg;
        reversal = 1'b0;
        // Small fluctuation is treated as zero speed
        if ((W+10)'(abs_w(W'(delta))) > band)
        begin
            dir_next = delta[W] ? 2'h2 : 2'h1;
            reversal = lost_on && (dir_reg != 2'h0) &&
                       (dir_next != dir_reg);
        end
    end

    // ----------------------------------------
    // Start delay and amount selection
    // ----------------------------------------
    logic        [15:0]  delay_reg;
    logic        [15:0]  delay_next;
    logic        [15:0]  tick_cnt_reg;
    logic        [15:0]  tick_cnt_next;
    logic                pend_reg;
    logic                pend_next;
    logic signed [W-1:0] step_reg;
    logic signed [W-1:0] step_next;
    logic                tick;
    logic                fire;

    assign tick = tick_cnt_reg == 16'(RFC_TICK_CYCLES - 1);

    always_comb
    begin
        // Restart on reversal so one delay unit lasts one full unit
        if (tick || reversal)
        begin
            tick_cnt_next = 16'h0000;
        end
        else
        begin
            tick_cnt_next = tick_cnt_reg + 16'h0001;
        end
        pend_next     = pend_reg;
        delay_next    = delay_reg;
        step_next     = step_reg;
        fire          = 1'b0;
        if (reversal)
        begin
            // A fresh reversal restarts the delay for the new direction
            pend_next  = 1'b1;
            delay_next = COMP_DELAY_TIME_IN;
            step_next  = (dir_next == 2'h2)
                         ? W'(-COMP_AMOUNT_DIR_ONE_IN)
                         : COMP_AMOUNT_DIR_TWO_IN;
        end
        else if (pend_reg)
        begin
            if (delay_reg == 16'h0000)
            begin
                fire      = 1'b1;
                pend_next = 1'b0;
            end
            else if (tick)
                delay_next = delay_reg - 16'h0001;
        end
    end

    // ----------------------------------------
    // Torque addition
    // ----------------------------------------
    logic signed [W-1:0] hp_value;
    logic signed [W-1:0] torque_next;

    // Filter reloads zero while disabled so no stale step comes back
    rfc_highpass #(
        .W(W)
    ) u_hp (
        .clk_in    (CLK_SYS_IN),
        .rst_in    (RST_IN),
        .tick_in   (tick),
        .load_in   (fire || !lost_on),
        .step_in   (lost_on ? step_reg : W'(0)),
        .tc_in     (COMP_HIGHPASS_TC_IN),
        .value_out (hp_value)
    );

    // Held step unless filter is set; filter bleeds it away
    assign torque_next = TORQUE_CMD_IN + hp_value;

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            droop_comp_reg         <= '0;
            inpos_reg              <= 1'b0;
            prev_droop_reg         <= '0;
            dir_reg                <= 2'h0;
            delay_reg              <= RFC_DELAY_RESET;
            tick_cnt_reg           <= 16'h0000;
            pend_reg               <= 1'b0;
            step_reg               <= '0;
            TORQUE_CMD_OUT         <= '0;
            REVERSAL_OUT           <= 1'b0;
        end
        else
        begin
            droop_comp_reg         <= droop_comp_next;
            inpos_reg              <= inpos_next;
            prev_droop_reg         <= DROOP_IN;
            dir_reg                <= lost_on ? dir_next : 2'h0;
            delay_reg              <= delay_next;
            tick_cnt_reg           <= tick_cnt_next;
            pend_reg               <= lost_on && pend_next;
            step_reg               <= step_next;
            TORQUE_CMD_OUT         <= torque_next;
            REVERSAL_OUT           <= reversal;
        end
    end

    assign DROOP_COMP_OUT         = droop_comp_reg;
    assign IN_POSITION_OUTPUT_OUT = inpos_reg;
endmodule
`default_nettype wire

// File: rfc_checker.sv
`default_nettype none
module rfc_checker
    import rfc_pkg::*;
#(
    parameter int W = 24
)
(
    // Clock and reset
    input wire logic                CLK_SYS_IN,
    input wire logic                RST_IN,
    // Watched inputs
    input wire rfc_mode_t           CTRL_MODE_IN,
    input wire logic        [1:0]   TRACE_COMP_SELECT_IN,
    input wire logic        [1:0]   ADAPTIVE_MODEL_SELECT_IN,
    input wire logic                INPOS_CONDITION_SELECT_IN,
    input wire logic                BACKLASH_COMP_ENABLE_IN,
    input wire logic        [W-1:0] INPOS_RANGE_IN,
    input wire logic signed [W-1:0] DROOP_IN,
    input wire logic signed [W-1:0] MODEL_DROOP_IN,
    input wire logic signed [W-1:0] TORQUE_CMD_IN,
    input wire logic                CMD_DONE_IN,
    // Watched outputs
    input wire logic signed [W-1:0] DROOP_COMP_OUT,
    input wire logic signed [W-1:0] TORQUE_CMD_OUT,
    input wire logic                IN_POSITION_OUTPUT_OUT,
    input wire logic                REVERSAL_OUT
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    wire logic pos_m = CTRL_MODE_IN <= RFC_MODE_POSITIONING;
    wire logic [W-1:0] mag = DROOP_IN[W-1] ? -DROOP_IN : DROOP_IN;
    sequence s_on;
        pos_m && TRACE_COMP_SELECT_IN == RFC_TRACE_ENABLED
        && ADAPTIVE_MODEL_SELECT_IN != RFC_ADAPT_PID;
    endsequence
    sequence s_off2;
        !BACKLASH_COMP_ENABLE_IN && !$past(RST_IN)
        ##1 !BACKLASH_COMP_ENABLE_IN;
    endsequence
    chk_droop_mode: assert property (
        !pos_m |=> DROOP_COMP_OUT == '0)
        else $error("droop comp outside position modes");
    chk_droop_pid: assert property (
        ADAPTIVE_MODEL_SELECT_IN == RFC_ADAPT_PID |=> DROOP_COMP_OUT == '0)
        else $error("droop comp under PID");
    chk_droop_on: assert property (
        s_on |=> DROOP_COMP_OUT == -$past(MODEL_DROOP_IN))
        else $error("droop comp does not cancel model droop");
    chk_droop_off: assert property (
        TRACE_COMP_SELECT_IN != RFC_TRACE_ENABLED |=> DROOP_COMP_OUT == '0)
        else $error("droop comp without enable");
    chk_inpos_done: assert property (
        INPOS_CONDITION_SELECT_IN == RFC_INP_CMD_DONE && !CMD_DONE_IN
        |=> !IN_POSITION_OUTPUT_OUT)
        else $error("in-position before command done");
    chk_inpos_range: assert property (
        IN_POSITION_OUTPUT_OUT |-> $past(mag) <= $past(INPOS_RANGE_IN))
        else $error("in-position outside range");
    chk_rev_mode: assert property (!pos_m |=> !REVERSAL_OUT)
        else $error("reversal outside position modes");
    chk_rev_enable: assert property (
        !BACKLASH_COMP_ENABLE_IN |=> !REVERSAL_OUT)
        else $error("reversal while disabled");
    chk_torque_pass: assert property (
        s_off2 |=> TORQUE_CMD_OUT == $past(TORQUE_CMD_IN))
        else $error("torque altered while disabled");
endmodule
`default_nettype wire

// File: rfc_motor_model.sv
`default_nettype none
module rfc_motor_model
#(
    parameter int W = 24
)
(
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic signed [W-1:0] speed_in,
    output var  logic signed [W-1:0] droop_out
);
    // Encoder count stands still at zero speed
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in)
            droop_out <= '0;
        else
            droop_out <= droop_out + speed_in;
endmodule
`default_nettype wire

// File: tb_top.sv
`default_nettype none
module tb_top;
    import rfc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 24;
    logic clk, rst, inpc, bl_en, unit, done, inpos, rev;
    rfc_mode_t mode;
    logic [1:0] trace, adapt;
    logic [15:0] dly, band, tc;
    logic [W-1:0] range;
    logic signed [W-1:0] amt1, amt2, speed, mdl, tq, dcomp, tq_o, droop;
    int n_fail, checks_done, nrev, cycles;
    rfc_top #(.W(W)) rfc_top_i (.CLK_SYS_IN(clk), .RST_IN(rst),
        .CTRL_MODE_IN(mode), .TRACE_COMP_SELECT_IN(trace),
        .ADAPTIVE_MODEL_SELECT_IN(adapt), .INPOS_CONDITION_SELECT_IN(inpc),
        .BACKLASH_COMP_ENABLE_IN(bl_en), .DEADBAND_UNIT_SELECT_IN(unit),
        .COMP_AMOUNT_DIR_ONE_IN(amt1), .COMP_AMOUNT_DIR_TWO_IN(amt2),
        .COMP_DELAY_TIME_IN(dly), .COMP_DEADBAND_IN(band),
        .COMP_HIGHPASS_TC_IN(tc), .INPOS_RANGE_IN(range),
        .DROOP_IN(droop), .MODEL_DROOP_IN(mdl), .TORQUE_CMD_IN(tq),
        .CMD_DONE_IN(done), .DROOP_COMP_OUT(dcomp), .TORQUE_CMD_OUT(tq_o),
        .IN_POSITION_OUTPUT_OUT(inpos), .REVERSAL_OUT(rev));
    rfc_motor_model #(.W(W)) rfc_motor_model_i (.clk_in(clk), .rst_in(rst),
        .speed_in(speed), .droop_out(droop));
    // ----
    // Helpers
    // ----
    task chk(string nm, logic [W-1:0] s, logic [W-1:0] e);
        checks_done++;
        if (s !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task settle(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task move(int v, int n);
        @(posedge clk);
        speed <= v;
        repeat (n)
        begin
            @(negedge clk);
            if (rev === 1'b1) nrev++;
        end
    endtask
    task results;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task t_inpos;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            inpc <= i[1];
            done <= i[0];
            settle(2);
            chk("inpos", inpos, W'(i != 2));
        end
        move(10, 3);
        move(0, 2);
        chk("inpos_far", inpos, 0);
    endtask
    task t_droop;
        for (int m = 0; m < 4; m++)
            for (int a = 0; a < 3; a += 2)
                for (int t = 0; t < 4; t++)
                begin
                    @(posedge clk);
                    mode <= rfc_mode_t'(m);
                    adapt <= 2'(a);
                    trace <= 2'(t);
                    settle(2);
                    // Feedforward assumed on outside while enabled
                    chk("droop", dcomp,
                        (m < 2 && t == 2 && a != 2) ? -mdl : 0);
                end
        @(posedge clk);
        mode <= RFC_MODE_POSITION;
        adapt <= 2'h0;
        trace <= 2'h0;
    endtask
    task t_lost;
        bl_en <= 1'b1;
        nrev = 0;
        move(5, 6);
        move(-5, 6);
        chk("rev_one", nrev, 1);
        chk("to_rev", tq_o, tq - amt1);
        move(5, 6);
        move(5, 20);
        chk("rev_two", nrev, 2);
        chk("to_fwd", tq_o, tq + amt2);
        @(posedge clk);
        dly <= 16'h0001;
        move(-5, 9000);
        chk("early", tq_o === tq - amt1, 0);
        move(-5, 1100);
        chk("late", tq_o, tq - amt1);
        @(posedge clk);
        dly <= 16'h0000;
        tc <= 16'h0010;
        move(5, 25000);
        chk("decay", tq_o < tq + amt2 && tq_o > tq, 1);
        @(posedge clk);
        tc <= 16'h0000;
    endtask
    task t_band;
        unit <= RFC_UNIT_KPULSE;
        band <= 16'h0001;
        nrev = 0;
        repeat (4)
        begin
            move(500, 2);
            move(-500, 2);
        end
        chk("dither_kp", nrev, 0);
        @(posedge clk);
        unit <= 1'b0;
        repeat (4)
        begin
            move(500, 2);
            move(-500, 2);
        end
        chk("dither_p", nrev > 2, 1);
        @(posedge clk);
        band <= 16'h0002;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            mode <= i ? RFC_MODE_POSITION : RFC_MODE_SPEED;
            bl_en <= i[0] ? 1'b0 : 1'b1;
            nrev = 0;
            move(5, 4);
            move(-5, 4);
            chk("off_rev", nrev, 0);
            chk("off_tq", tq_o, tq);
        end
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_fail++;
            results();
        end
    end
    initial
    begin
        {rst, inpc, bl_en, unit, done, trace, adapt} = '0;
        rst = 1'b1;
        mode = RFC_MODE_POSITION;
        {dly, tc} = '0;
        band = 16'h0002;
        range = 24'h000005;
        amt1 = 24'h000040;
        amt2 = 24'h000070;
        speed = '0;
        mdl = 24'h000123;
        tq = 24'h000100;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_inpos();
        t_droop();
        t_lost();
        t_band();
        results();
    end
endmodule
bind rfc_top rfc_checker #(.W(W)) rfc_checker_i (
    .CLK_SYS_IN                (CLK_SYS_IN),
    .RST_IN                    (RST_IN),
    .CTRL_MODE_IN              (CTRL_MODE_IN),
    .TRACE_COMP_SELECT_IN      (TRACE_COMP_SELECT_IN),
    .ADAPTIVE_MODEL_SELECT_IN  (ADAPTIVE_MODEL_SELECT_IN),
    .INPOS_CONDITION_SELECT_IN (INPOS_CONDITION_SELECT_IN),
    .BACKLASH_COMP_ENABLE_IN   (BACKLASH_COMP_ENABLE_IN),
    .INPOS_RANGE_IN            (INPOS_RANGE_IN),
    .DROOP_IN                  (DROOP_IN),
    .MODEL_DROOP_IN            (MODEL_DROOP_IN),
    .TORQUE_CMD_IN             (TORQUE_CMD_IN),
    .CMD_DONE_IN               (CMD_DONE_IN),
    .DROOP_COMP_OUT            (DROOP_COMP_OUT),
    .TORQUE_CMD_OUT            (TORQUE_CMD_OUT),
    .IN_POSITION_OUTPUT_OUT    (IN_POSITION_OUTPUT_OUT),
    .REVERSAL_OUT              (REVERSAL_OUT)
);
`default_nettype wire
